//--- canmc_defs.vh
// Purpose: constants for the mode and clock-output controller
// Assumes: 8-bit registers, one per 32-bit Wishbone word, byte address = 4 * index
// Notes:   included by canmc_mode_clock.v
`ifndef CANMC_DEFS_VH
`define CANMC_DEFS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CANMC_IDX_SENDPIN  6'h0d
`define CANMC_IDX_STAT     6'h0e
`define CANMC_IDX_CTRL     6'h0f
`define CANMC_IDX_TEC      6'h1c
`define CANMC_IDX_REC      6'h1d
`define CANMC_IDX_CFGC     6'h28
`define CANMC_IDX_CFGB     6'h29
`define CANMC_IDX_CFGA     6'h2a
`define CANMC_IDX_IEN      6'h2b
`define CANMC_IDX_IFLG     6'h2c
`define CANMC_IDX_FB0      6'h00
`define CANMC_IDX_FB0_END  6'h0c
`define CANMC_IDX_FB1      6'h10
`define CANMC_IDX_FB1_END  6'h1c
`define CANMC_IDX_FB2      6'h20
`define CANMC_IDX_FB2_END  6'h28
`define CANMC_FB1_SHIFT    6'h04
`define CANMC_FB2_SHIFT    6'h08

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CANMC_REQ_HI       7
`define CANMC_REQ_LO       5
`define CANMC_ABAT_BIT     4
`define CANMC_CLOCK_OUTPUT_ENABLE_BIT    2
`define CANMC_PRE_HI       1
`define CANMC_WAKE_BIT     6
`define CANMC_WAKE_GLITCH_FILTER_ENABLE_BIT   6
`define CANMC_CTRL_RST     8'he7
`define CANMC_REG_RST      8'h00

// ----------------------------------------
// Modes and divider codes
// ----------------------------------------
`define CANMC_MODE_NORMAL  3'h0
`define CANMC_MODE_SLEEP   3'h1
`define CANMC_MODE_LOOP    3'h2
`define CANMC_MODE_LISTEN  3'h3
`define CANMC_MODE_CONFIG  3'h4
`define CANMC_DIV1         2'h0
`define CANMC_DIV2         2'h1
`define CANMC_DIV4         2'h2
`define CANMC_DIV8         2'h3

// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define CANMC_HOLD_LAST    7'h7f
`define CANMC_SLEEP_CLKS   5'h10
`define CANMC_WAKE_FILT    4'h8
`define CANMC_IDLE_CYC     4'hb

`endif

//--- canmc_mode_clock.v
// Purpose: operating mode control, startup hold-off and clock output pin
// Assumes: clk_in is the oscillator; protocol engine sits on the same clock
// Notes:   classic Wishbone slave, ack one cycle after the strobe is seen
`include "canmc_defs.vh"

module canmc_mode_clock (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_b_in,
   // Wishbone slave
   input  wire        wb_cyc_in,
   input  wire        wb_stb_in,
   input  wire        wb_we_in,
   input  wire [7:0]  wb_adr_in,
   input  wire [3:0]  wb_sel_in,
   input  wire [31:0] wb_dat_in,
   output wire [31:0] wb_dat_out,
   output wire        wb_ack_out,
   // Protocol engine
   input  wire        tx_pending_in,
   input  wire        engine_tx_in,
   input  wire [7:0]  tec_in,
   input  wire [7:0]  rec_in,
   input  wire [4:0]  filt_idx_in,
   output wire [7:0]  filt_dat_out,
   output wire [2:0]  current_mode_out,
   output wire        tx_enable_out,
   output wire        tx_abort_out,
   output wire        abort_all_out,
   output wire        rx_to_engine_out,
   output wire        rx_discard_out,
   output wire        err_cnt_clear_out,
   output wire        core_reset_b_out,
   output wire        osc_run_out,
   output wire        wake_flag_out,
   output wire [7:0]  bit_timing_cfg_a_out,
   output wire [7:0]  bit_timing_cfg_b_out,
   output wire [7:0]  bit_timing_cfg_c_out,
   output wire [7:0]  send_pin_control_out,
   // Bus pins
   input  wire        bus_rx_line_in,
   output wire        bus_tx_line_out,
   // Clock output pin
   output wire        clock_output_pin_out,
   output wire        clock_output_pin_oe_b_out
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   reg        rx_m_q, rx_s_q;
   reg        hold_q;
   reg [6:0]  hold_cnt_q;
   reg [2:0]  mode_request_q;
   reg        abat_q, clock_output_enable_q;
   reg [1:0]  clock_output_divider_q;
   reg [2:0]  current_mode_q;
   reg [7:0]  cfg_a_q, cfg_b_q, cfg_c_q, send_q, ien_q, iflg_q;
   reg [7:0]  filt_q [0:31];
   reg [7:0]  filt_dat_q;
   reg        ack_q;
   reg [7:0]  dat_q;
   reg        slp_pend_q;
   reg [4:0]  slp_cnt_q;
   reg [3:0]  wfilt_cnt_q, idle_cnt_q;
   reg        disc_q, errclr_q, tx_q, rxe_q;
   reg        run_q, slow_q, stop_q, gate_q;
   reg [1:0]  sel_q, ph_q;
   localparam [7:0] ctrl_rst = `CANMC_CTRL_RST;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire       acc    = wb_cyc_in & wb_stb_in & ~ack_q;
   wire       wr     = acc & wb_we_in & wb_sel_in[0];
   wire [5:0] idx    = wb_adr_in[7:2];
   wire       cfg_ok = (current_mode_q == `CANMC_MODE_CONFIG);
   wire       in_slp = (current_mode_q == `CANMC_MODE_SLEEP);
   reg        filt_hit;
   reg [5:0]  filt_sel;
   reg [7:0]  rd;

   always @* begin
      filt_hit = 1'b0;
      filt_sel = 6'h00;
      if (idx < `CANMC_IDX_FB0_END) begin
         filt_hit = 1'b1;
         filt_sel = idx;
      end else if (idx >= `CANMC_IDX_FB1 && idx < `CANMC_IDX_FB1_END) begin
         filt_hit = 1'b1;
         filt_sel = idx - `CANMC_FB1_SHIFT;
      end else if (idx >= `CANMC_IDX_FB2 && idx < `CANMC_IDX_FB2_END) begin
         filt_hit = 1'b1;
         filt_sel = idx - `CANMC_FB2_SHIFT;
      end
   end

   always @* begin
      rd = 8'h00;
      case (idx)
         `CANMC_IDX_SENDPIN: rd = send_q;
         `CANMC_IDX_STAT:    rd = {current_mode_q, 5'h00};
         `CANMC_IDX_CTRL:    rd = {mode_request_q, abat_q, 1'b0, clock_output_enable_q, clock_output_divider_q};
         `CANMC_IDX_TEC:     rd = tec_in;
         `CANMC_IDX_REC:     rd = rec_in;
         `CANMC_IDX_CFGC:    rd = cfg_c_q;
         `CANMC_IDX_CFGB:    rd = cfg_b_q;
         `CANMC_IDX_CFGA:    rd = cfg_a_q;
         `CANMC_IDX_IEN:     rd = ien_q;
         `CANMC_IDX_IFLG:    rd = iflg_q;
         default:            rd = filt_hit ? filt_q[filt_sel[4:0]] : 8'h00;
      endcase
   end

   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         ack_q <= 1'b0;
         dat_q <= 8'h00;
      end else begin
         ack_q <= acc;
         if (acc) begin
            dat_q <= rd;
         end
      end
   end

   // ----------------------------------------
   // Receive line sync and wake detection
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
      end else begin
         rx_m_q <= bus_rx_line_in;
         rx_s_q <= rx_m_q;
      end
   end

   // Filter trades wake latency for immunity to short dominant spikes
   wire rx_act    = cfg_c_q[`CANMC_WAKE_GLITCH_FILTER_ENABLE_BIT] ? (wfilt_cnt_q == `CANMC_WAKE_FILT) : ~rx_s_q;
   wire host_wake = wr & (idx == `CANMC_IDX_IFLG) & wb_dat_in[`CANMC_WAKE_BIT] & ~iflg_q[`CANMC_WAKE_BIT];
   wire wake      = in_slp & ((rx_act & ien_q[`CANMC_WAKE_BIT]) | host_wake);

   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         wfilt_cnt_q <= 4'h0;
         idle_cnt_q  <= 4'h0;
         disc_q      <= 1'b0;
      end else begin
         if (!in_slp || rx_s_q) begin
            wfilt_cnt_q <= 4'h0;
         end else if (wfilt_cnt_q != `CANMC_WAKE_FILT) begin
            wfilt_cnt_q <= wfilt_cnt_q + 4'h1;
         end
         if (!rx_s_q) begin
            idle_cnt_q <= 4'h0;
         end else if (idle_cnt_q != `CANMC_IDLE_CYC) begin
            idle_cnt_q <= idle_cnt_q + 4'h1;
         end
         // Drop traffic until hold-off ends and the bus has gone idle
         if (wake) begin
            disc_q <= 1'b1;
         end else if (!hold_q && idle_cnt_q == `CANMC_IDLE_CYC) begin
            disc_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Startup hold-off
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         hold_q     <= 1'b1;
         hold_cnt_q <= 7'h00;
      end else if (wake) begin
         hold_q     <= 1'b1;
         hold_cnt_q <= 7'h00;
      end else if (hold_q) begin
         hold_cnt_q <= hold_cnt_q + 7'h01;
         if (hold_cnt_q == `CANMC_HOLD_LAST) begin
            hold_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         mode_request_q         <= ctrl_rst[`CANMC_REQ_HI:`CANMC_REQ_LO];
         abat_q                 <= ctrl_rst[`CANMC_ABAT_BIT];
         clock_output_enable_q  <= ctrl_rst[`CANMC_CLOCK_OUTPUT_ENABLE_BIT];
         clock_output_divider_q <= `CANMC_DIV8;
         cfg_a_q                <= `CANMC_REG_RST;
         cfg_b_q                <= `CANMC_REG_RST;
         cfg_c_q                <= `CANMC_REG_RST;
         send_q                 <= `CANMC_REG_RST;
         ien_q                  <= `CANMC_REG_RST;
         iflg_q                 <= `CANMC_REG_RST;
      end else begin
         if (wr) begin
            case (idx)
               `CANMC_IDX_CTRL: begin
                  mode_request_q         <= wb_dat_in[`CANMC_REQ_HI:`CANMC_REQ_LO];
                  abat_q                 <= wb_dat_in[`CANMC_ABAT_BIT];
                  clock_output_enable_q  <= wb_dat_in[`CANMC_CLOCK_OUTPUT_ENABLE_BIT];
                  clock_output_divider_q <= wb_dat_in[`CANMC_PRE_HI:0];
               end
               `CANMC_IDX_CFGA:    if (cfg_ok) cfg_a_q <= wb_dat_in[7:0];
               `CANMC_IDX_CFGB:    if (cfg_ok) cfg_b_q <= wb_dat_in[7:0];
               `CANMC_IDX_CFGC:    if (cfg_ok) cfg_c_q <= wb_dat_in[7:0];
               `CANMC_IDX_SENDPIN: if (cfg_ok) send_q <= wb_dat_in[7:0];
               `CANMC_IDX_IEN:     ien_q <= wb_dat_in[7:0];
               `CANMC_IDX_IFLG:    iflg_q <= wb_dat_in[7:0];
               default:            ien_q <= ien_q;
            endcase
         end
         // Hardware set wins over a clearing write in the same cycle
         if (wake) begin
            iflg_q[`CANMC_WAKE_BIT] <= 1'b1;
            mode_request_q          <= `CANMC_MODE_LISTEN;
         end
      end
   end

   always @(posedge clk_in) begin
      if (wr && filt_hit && cfg_ok) begin
         filt_q[filt_sel[4:0]] <= wb_dat_in[7:0];
      end
      filt_dat_q <= filt_q[filt_idx_in];
   end

   // ----------------------------------------
   // Mode control
   // ----------------------------------------
   wire req_ok = (mode_request_q <= `CANMC_MODE_CONFIG);
   wire cyc_done;
   wire slp_done = ~run_q | (slp_cnt_q == `CANMC_SLEEP_CLKS);
   wire go_mode  = ~hold_q & ~slp_pend_q & ~in_slp & req_ok & ~tx_pending_in
                   & (mode_request_q != current_mode_q) & (mode_request_q != `CANMC_MODE_SLEEP);

   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         current_mode_q <= `CANMC_MODE_CONFIG;
         slp_pend_q     <= 1'b0;
         slp_cnt_q      <= 5'h00;
         errclr_q       <= 1'b1;
      end else begin
         errclr_q <= (current_mode_q == `CANMC_MODE_LISTEN) | (go_mode & (mode_request_q == `CANMC_MODE_CONFIG));
         if (wake) begin
            current_mode_q <= `CANMC_MODE_LISTEN;
         end else if (!hold_q && slp_pend_q) begin
            if (slp_done) begin
               current_mode_q <= `CANMC_MODE_SLEEP;
               slp_pend_q     <= 1'b0;
            end else if (cyc_done) begin
               slp_cnt_q <= slp_cnt_q + 5'h01;
            end
         end else if (!hold_q && !in_slp && mode_request_q == `CANMC_MODE_SLEEP) begin
            slp_pend_q <= 1'b1;
            slp_cnt_q  <= 5'h00;
         end else if (go_mode) begin
            current_mode_q <= mode_request_q;
         end
      end
   end

   // Transmit line only follows the engine in normal mode
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         tx_q  <= 1'b1;
         rxe_q <= 1'b1;
      end else begin
         tx_q  <= (current_mode_q == `CANMC_MODE_NORMAL && !hold_q) ? engine_tx_in : 1'b1;
         rxe_q <= (current_mode_q == `CANMC_MODE_LOOP) ? engine_tx_in : rx_s_q;
      end
   end

   // ----------------------------------------
   // Clock output
   // ----------------------------------------
   wire [1:0] half_m1  = (sel_q == `CANMC_DIV8) ? 2'h3 : ((sel_q == `CANMC_DIV4) ? 2'h1 : 2'h0);
   wire       ph_end   = (ph_q == half_m1);
   wire       want_run = clock_output_enable_q & ~in_slp;
   wire       change   = (want_run != run_q) | (clock_output_divider_q != sel_q);
   // Settings switch only after a full low phase, so no runt pulse appears
   wire       bound    = ~run_q | ((sel_q == `CANMC_DIV1) ? (stop_q & ~gate_q) : (~slow_q & ph_end));
   assign cyc_done = run_q & ((sel_q == `CANMC_DIV1) ? gate_q : (slow_q & ph_end));

   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         run_q  <= 1'b1;
         sel_q  <= `CANMC_DIV8;
         slow_q <= 1'b0;
         ph_q   <= 2'h0;
         stop_q <= 1'b0;
      end else begin
         stop_q <= run_q & (sel_q == `CANMC_DIV1) & change;
         if (run_q && sel_q != `CANMC_DIV1) begin
            if (ph_end) begin
               slow_q <= ~slow_q;
               ph_q   <= 2'h0;
            end else begin
               ph_q <= ph_q + 2'h1;
            end
         end
         if (bound && change) begin
            run_q  <= want_run;
            sel_q  <= clock_output_divider_q;
            slow_q <= want_run & (clock_output_divider_q != `CANMC_DIV1);
            ph_q   <= 2'h0;
            stop_q <= 1'b0;
         end
      end
   end

   // Gate opens and closes while the clock is low
   always @(negedge clk_in) begin
      if (!rst_b_in) begin
         gate_q <= 1'b0;
      end else begin
         gate_q <= run_q & (sel_q == `CANMC_DIV1) & ~stop_q;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign clock_output_pin_out      = (sel_q == `CANMC_DIV1) ? (clk_in & gate_q) : slow_q;
   assign clock_output_pin_oe_b_out = ~(run_q | clock_output_enable_q);
   assign bus_tx_line_out       = tx_q;
   assign wb_ack_out            = ack_q;
   assign wb_dat_out            = {24'h000000, dat_q};
   assign filt_dat_out          = filt_dat_q;
   assign current_mode_out      = current_mode_q;
   assign tx_enable_out         = (current_mode_q == `CANMC_MODE_NORMAL);
   assign tx_abort_out          = slp_pend_q | in_slp;
   assign abort_all_out         = abat_q;
   assign rx_to_engine_out      = rxe_q;
   assign rx_discard_out        = disc_q;
   assign err_cnt_clear_out     = errclr_q;
   assign core_reset_b_out      = ~hold_q;
   assign osc_run_out           = ~in_slp;
   assign wake_flag_out         = iflg_q[`CANMC_WAKE_BIT];
   assign bit_timing_cfg_a_out  = cfg_a_q;
   assign bit_timing_cfg_b_out  = cfg_b_q;
   assign bit_timing_cfg_c_out  = cfg_c_q;
   assign send_pin_control_out  = send_q;

endmodule // canmc_mode_clock

//--- canmc_props.sv
// Purpose: port assertions for the mode and clock controller
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the bench top file
`include "canmc_defs.vh"
module canmc_props (
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   // Register bus
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [7:0]  wb_adr_in,
   input wire logic [3:0]  wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic        wb_ack_out,
   // Engine and pins
   input wire logic        tx_pending_in,
   input wire logic [2:0]  current_mode_out,
   input wire logic        tx_enable_out,
   input wire logic        err_cnt_clear_out,
   input wire logic        core_reset_b_out,
   input wire logic        osc_run_out,
   input wire logic [7:0]  bit_timing_cfg_a_out,
   input wire logic        bus_tx_line_out,
   input wire logic        clock_output_pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic [7:0] hold_q;
   logic       wr;
   logic [2:0] m;
   assign m  = current_mode_out;
   assign wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0] && !wb_ack_out;
   // Saturates so a stuck hold-off cannot wrap back into range
   always @(posedge clk_in) begin
      if (!rst_b_in || core_reset_b_out) begin
         hold_q <= 8'h00;
      end else if (hold_q != 8'hff) begin
         hold_q <= hold_q + 8'h01;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_ack_single: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
      else $error("ack not a single pulse");
   a_hold_len: assert property ($rose(core_reset_b_out) |-> hold_q >= 8'h7e && hold_q <= 8'h82)
      else $error("hold-off length wrong");
   a_tx_normal: assert property (tx_enable_out == (m == `CANMC_MODE_NORMAL))
      else $error("transmit enable outside normal mode");
   a_silent_bus: assert property (
      m != `CANMC_MODE_NORMAL && $past(m) != `CANMC_MODE_NORMAL |-> bus_tx_line_out)
      else $error("bus driven outside normal mode");
   a_sleep_quiet: assert property (
      m == `CANMC_MODE_SLEEP && $past(m) == `CANMC_MODE_SLEEP |-> !osc_run_out && !clock_output_pin_out)
      else $error("oscillator or clock output active in sleep");
   a_listen_clr: assert property (
      m == `CANMC_MODE_LISTEN && $past(m) == `CANMC_MODE_LISTEN |-> err_cnt_clear_out)
      else $error("error counters not held in listen-only");
   a_config_clr: assert property (
      m == `CANMC_MODE_CONFIG && $past(m) != `CANMC_MODE_CONFIG |-> ##[0:1] err_cnt_clear_out)
      else $error("error counters not cleared on config entry");
   a_defer_mode: assert property (
      $past(tx_pending_in) && $past(m) != `CANMC_MODE_SLEEP && m != `CANMC_MODE_SLEEP |-> m == $past(m))
      else $error("mode changed with transmission pending");
   a_mode_code: assert property (m <= `CANMC_MODE_CONFIG)
      else $error("undefined mode code");
   a_bad_req: assert property (
      wr && wb_adr_in[7:2] == `CANMC_IDX_CTRL && wb_dat_in[7:5] > `CANMC_MODE_CONFIG |=> $stable(m) [*3])
      else $error("undefined request changed mode");
   a_cfg_lock: assert property (
      wr && wb_adr_in[7:2] == `CANMC_IDX_CFGA && m != `CANMC_MODE_CONFIG |=> $stable(bit_timing_cfg_a_out) [*2])
      else $error("bit timing written outside config");
endmodule // canmc_props

//--- canmc_engine_model.sv
// Purpose: engine and bus-side stand-in for the mode controller
// Assumes: one frame at a time, fifteen bit times of one clock
// Notes:   receive line idles recessive, as with the bus pull-up
module canmc_engine_model (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   // Bench controls
   input  wire logic frame_req_in,
   input  wire logic bus_drive_in,
   // From the controller
   input  wire logic tx_enable_in,
   input  wire logic tx_abort_in,
   // To the controller
   output logic      tx_pending_out,
   output logic      engine_tx_out,
   output logic      bus_rx_line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] bits_q;
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         bits_q         <= 4'h0;
         tx_pending_out <= 1'b0;
      end else if (frame_req_in) begin
         bits_q         <= 4'hf;
         tx_pending_out <= 1'b1;
      end else if (tx_pending_out && tx_enable_in && !tx_abort_in) begin
         bits_q         <= bits_q - 4'h1;
         tx_pending_out <= (bits_q != 4'h1);
      end
      // Aborted frame stays pending
   end
   assign engine_tx_out   = !(tx_pending_out && bits_q[0]);
   assign bus_rx_line_out = bus_drive_in;
endmodule // canmc_engine_model

//--- canmc_mode_clock_tb.sv
// Purpose: self-checking bench for the mode and clock controller
// Assumes: 20 MHz clock, byte address = 4 * register index
// Notes:   counter and filter read inputs tied, unused here
`include "canmc_defs.vh"
module canmc_mode_clock_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   localparam logic [7:0] ad_ctrl = {`CANMC_IDX_CTRL, 2'b00};
   localparam logic [7:0] ad_stat = {`CANMC_IDX_STAT, 2'b00};
   localparam logic [7:0] ad_cfga = {`CANMC_IDX_CFGA, 2'b00};
   localparam logic [7:0] ad_cfgc = {`CANMC_IDX_CFGC, 2'b00};
   localparam logic [7:0] ad_ien  = {`CANMC_IDX_IEN, 2'b00};
   localparam logic [7:0] ad_flg  = {`CANMC_IDX_IFLG, 2'b00};
   logic        clk_in, rst_b_in, cyc, stb, we, ack, frame_req, bus_drive;
   logic        pend, etx, brx, txen, abrt, cr_b, pin, oe_b, wflag, osc, btx, discard, eclr;
   logic [2:0]  mode;
   logic [3:0]  sel;
   logic [7:0]  adr, cfga;
   logic [31:0] wdat, rdat, q;
   int          n_errors, total_checks, h;
   int          cycles = 0;
   canmc_mode_clock canmc_mode_clock_i (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .tx_pending_in(pend), .engine_tx_in(etx), .tec_in(8'h00), .rec_in(8'h00), .filt_idx_in(5'h00),
      .filt_dat_out(), .current_mode_out(mode), .tx_enable_out(txen), .tx_abort_out(abrt),
      .abort_all_out(), .rx_to_engine_out(), .rx_discard_out(discard), .err_cnt_clear_out(eclr),
      .core_reset_b_out(cr_b), .osc_run_out(osc), .wake_flag_out(wflag), .bit_timing_cfg_a_out(cfga),
      .bit_timing_cfg_b_out(), .bit_timing_cfg_c_out(), .send_pin_control_out(),
      .bus_rx_line_in(brx), .bus_tx_line_out(btx), .clock_output_pin_out(pin),
      .clock_output_pin_oe_b_out(oe_b));
   canmc_engine_model canmc_engine_model_i (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .frame_req_in(frame_req), .bus_drive_in(bus_drive),
      .tx_enable_in(txen), .tx_abort_in(abrt), .tx_pending_out(pend), .engine_tx_out(etx),
      .bus_rx_line_out(brx));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles > 6000) begin
         n_errors++;
         give_verdict;
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until ack is sampled, then one idle cycle
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      if (n >= 20) chk("wb_ack", 32'h0, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      wb(a, 1'b0, 8'h00);
      chk(nm, q, {24'h0, e});
   endtask
   task automatic wait_mode(input logic [2:0] m, input int lim);
      int n;
      n = 0;
      while (mode !== m && n < lim) begin
         @(posedge clk_in);
         n++;
      end
      chk("mode", 32'(mode), 32'(m));
   endtask
   // High-phase length of the clock output, in clocks
   task automatic meas;
      int n;
      n = 0;
      h = 0;
      while (pin !== 1'b0 && n < 80) begin @(posedge clk_in); n++; end
      while (pin !== 1'b1 && n < 80) begin @(posedge clk_in); n++; end
      while (pin === 1'b1 && n < 80) begin @(posedge clk_in); n++; h++; end
   endtask
   task automatic hold_wait(input int lo);
      int n;
      n = 0;
      while (cr_b !== 1'b1 && n < 200) begin @(posedge clk_in); n++; end
      chk("hold_len", 32'(n >= lo && n <= 130), 32'h1);
   endtask
   task automatic t_reset;
      chk("mode_rst", 32'(mode), 32'h4);
      chk("oe_b_rst", 32'(oe_b), 32'h0);
      hold_wait(124);
      meas;
      meas;
      chk("div8_high", h, 32'h4);
      rd(ad_ctrl, 8'he7, "ctrl_rst");
      rd(ad_stat, 8'h80, "stat_rst");
      rd(8'hc0, 8'h00, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_modes;
      wb(ad_cfga, 1'b1, 8'h5a);
      chk("cfga_cfg", 32'(cfga), 32'h5a);
      wb(ad_ctrl, 1'b1, 8'h07);
      wait_mode(3'h0, 10);
      rd(ad_stat, 8'h00, "stat_normal");
      chk("txen", 32'(txen), 32'h1);
      wb(ad_cfga, 1'b1, 8'ha5);
      chk("cfga_locked", 32'(cfga), 32'h5a);
      wb(ad_ctrl, 1'b1, 8'ha7);
      repeat (4) @(posedge clk_in);
      chk("bad_code", 32'(mode), 32'h0);
      frame_req <= 1'b1;
      @(posedge clk_in);
      frame_req <= 1'b0;
      wb(ad_ctrl, 1'b1, 8'h47);
      chk("deferred", 32'(mode), 32'h0);
      wait_mode(3'h2, 40);
      wb(ad_ctrl, 1'b1, 8'h67);
      wait_mode(3'h3, 10);
      @(posedge clk_in);
      chk("listen_clr", 32'(eclr), 32'h1);
      wb(ad_ctrl, 1'b1, 8'h87);
      wait_mode(3'h4, 10);
      rd(ad_stat, 8'h80, "stat_cfg");
      $display("test modes done");
   endtask
   task automatic t_divider;
      int n;
      for (int c = 1; c < 4; c++) begin
         wb(ad_ctrl, 1'b1, 8'h84 | 8'(c));
         meas;
         meas;
         chk("div_high", h, 32'(1 << (c - 1)));
      end
      wb(ad_ctrl, 1'b1, 8'h80);
      for (n = 0; oe_b !== 1'b1 && n < 40; n++) @(posedge clk_in);
      chk("oe_b_off", 32'(oe_b), 32'h1);
      wb(ad_ctrl, 1'b1, 8'h87);
      for (n = 0; oe_b !== 1'b0 && n < 40; n++) @(posedge clk_in);
      chk("oe_b_on", 32'(oe_b), 32'h0);
      $display("test divider done");
   endtask
   task automatic t_sleep;
      int   n, r;
      logic prev;
      wb(ad_cfgc, 1'b1, 8'h40);
      wb(ad_ien, 1'b1, 8'h40);
      wb(ad_ctrl, 1'b1, 8'h07);
      wait_mode(3'h0, 10);
      wb(ad_ctrl, 1'b1, 8'h27);
      rd(ad_stat, 8'h00, "stat_presleep");
      n = 0;
      r = 0;
      prev = pin;
      while (mode !== 3'h1 && n < 400) begin
         @(posedge clk_in);
         n++;
         if (pin === 1'b1 && prev === 1'b0) r++;
         prev = pin;
      end
      chk("clk_before_sleep", 32'(r >= 15 && r <= 17), 32'h1);
      repeat (2) @(posedge clk_in);
      chk("osc_sleep", 32'(osc), 32'h0);
      chk("btx_sleep", 32'(btx), 32'h1);
      chk("pin_sleep", 32'(pin), 32'h0);
      chk("abort", 32'(abrt), 32'h1);
      rd(ad_ctrl, 8'h27, "ctrl_sleep");
      // Dominant glitch shorter than the wake filter
      bus_drive <= 1'b0;
      repeat (3) @(posedge clk_in);
      bus_drive <= 1'b1;
      repeat (20) @(posedge clk_in);
      chk("glitch", 32'(mode), 32'h1);
      bus_drive <= 1'b0;
      wait_mode(3'h3, 60);
      bus_drive <= 1'b1;
      chk("wake_flag", 32'(wflag), 32'h1);
      chk("discard", 32'(discard), 32'h1);
      hold_wait(118);
      rd(ad_stat, 8'h60, "stat_listen");
      wb(ad_flg, 1'b1, 8'h00);
      wb(ad_ctrl, 1'b1, 8'h27);
      wait_mode(3'h1, 400);
      wb(ad_flg, 1'b1, 8'h40);
      wait_mode(3'h3, 10);
      $display("test sleep done");
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      rst_b_in = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      sel = 4'h1;
      frame_req = 1'b0;
      bus_drive = 1'b1;
      n_errors = 0;
      total_checks = 0;
      repeat (3) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      t_reset;
      t_modes;
      t_divider;
      t_sleep;
      give_verdict;
   end
endmodule // canmc_mode_clock_tb
bind canmc_mode_clock canmc_props canmc_props_i (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
   .wb_ack_out(wb_ack_out), .tx_pending_in(tx_pending_in), .current_mode_out(current_mode_out),
   .tx_enable_out(tx_enable_out), .err_cnt_clear_out(err_cnt_clear_out),
   .core_reset_b_out(core_reset_b_out), .osc_run_out(osc_run_out),
   .bit_timing_cfg_a_out(bit_timing_cfg_a_out), .bus_tx_line_out(bus_tx_line_out),
   .clock_output_pin_out(clock_output_pin_out));
